// file: src/usb_link_status_ctrl.sv
// register block for usb otg, serial line and line event flags
//
// Summary of operation
// - otg control bits 7 and 6 select and drive external vbus; bit 5 reserved.
// - otg control bits 4..0 drive charge, discharge, dm/dp pulldowns, id pullup.
// - otg status register is read-only, shows six transceiver session signals.
// - serial register bits 6..4 read differential, dminus and dplus lines.
// - serial bits 3..0: force se0, tx data, active-low enable (reset one), mode.
// - flag 6 sets on a non-sof token with good crc, pid and matching address.
// - flags 5, 4, 3 set on line state se0, k and j.
// - flag 2 sets when a data packet fails its crc16 check.
// - flag 1 follows receive-active, flag 0 follows receive-error.
// - non-sticky flags 6..2 clear when the next packet arrives.
// - stickiness bits 6:0 hold flags until software writes one to clear.
// - non-sticky flags 1 and 0 track their source; non-sticky flags 6..2 hold until cleared.
// - four 8-bit masks or selected flags onto four port outputs.
// - 11-bit frame counter, read/write, high bits 10:8, low bits 7:0.
// - all registers are reached with 32-bit reads and writes only.
// - any write to the reset register returns every register field and flag to reset, but not the synchronisers or port outputs.
// - device address is zero until enumeration, then loaded by software.
`timescale 1ns/1ps
module usb_link_status_ctrl
	import usb_link_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// peripheral register port
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	output logic [31:0] REG_RDATA_O,
	output logic REG_ACK_O,
	// transceiver status inputs
	input wire logic B_SESSION_VALID_I,
	input wire logic ID_GROUND_I,
	input wire logic HOST_DISCONNECT_I,
	input wire logic VBUS_VALID_I,
	input wire logic SESSION_VALID_I,
	input wire logic SESSION_END_I,
	input wire logic RX_DIFF_I,
	input wire logic RX_DMINUS_I,
	input wire logic RX_DPLUS_I,
	input wire logic [1:0] LINE_STATE_I,
	input wire logic RX_ACTIVE_I,
	input wire logic RX_ERROR_I,
	// packet engine events, same clock
	input wire logic PACKET_START_I,
	input wire logic TOKEN_GOOD_I,
	input wire logic TOKEN_IS_SOF_I,
	input wire logic [DEV_ADDR_W-1:0] TOKEN_ADDR_I,
	input wire logic [FRAME_W-1:0] TOKEN_FRAME_I,
	input wire logic DATA_CRC_FAIL_I,
	// transceiver otg controls
	output logic EXT_VBUS_IND_SEL_O,
	output logic EXT_VBUS_DRIVE_O,
	output logic VBUS_CHARGE_O,
	output logic VBUS_DISCHARGE_O,
	output logic DM_PULLDOWN_O,
	output logic DP_PULLDOWN_O,
	output logic ID_PULLUP_O,
	// transceiver serial controls
	output logic TX_FORCE_SE0_O,
	output logic TX_DATA_O,
	output logic TX_ENABLE_N_O,
	output logic FS_LS_SERIAL_O,
	// device address for token matching
	output logic [DEV_ADDR_W-1:0] DEVICE_ADDR_O,
	// flag-driven port outputs
	output logic [NUM_PORTS-1:0] PORT_FLAG_O
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisation

	phy_status_type phy_raw;
	phy_status_type phy_sync;

	assign phy_raw.b_session_valid_status = B_SESSION_VALID_I;
	assign phy_raw.id_ground_status = ID_GROUND_I;
	assign phy_raw.host_disconnect_status = HOST_DISCONNECT_I;
	assign phy_raw.vbus_valid_status = VBUS_VALID_I;
	assign phy_raw.session_valid_status = SESSION_VALID_I;
	assign phy_raw.session_end_status = SESSION_END_I;
	assign phy_raw.receive_diff_line = RX_DIFF_I;
	assign phy_raw.receive_dminus_line = RX_DMINUS_I;
	assign phy_raw.receive_dplus_line = RX_DPLUS_I;
	// carried inverted: a cleared synchroniser then reads as no line state
	// instead of a false se0 that would set its flag right after reset
	assign phy_raw.line_state = ~LINE_STATE_I;
	assign phy_raw.receive_active = RX_ACTIVE_I;
	assign phy_raw.receive_error = RX_ERROR_I;

	input_sync #(
		.WIDTH($bits(phy_status_type))
	) u_phy_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.async_i(phy_raw),
		.sync_o(phy_sync)
	);

	logic [1:0] line_state_sync;

	assign line_state_sync = ~phy_sync.line_state;

	////////////////////////////////////////////////////////////////////////
	// register access decode

	logic wr_hit;
	logic soft_rst;
	logic wr_dev_addr;
	logic wr_otg;
	logic wr_serial;
	logic wr_flags;
	logic wr_sticky;
	logic wr_masks;
	logic wr_frame;

	// only whole aligned words are taken
	assign wr_hit = REG_WR_I && (REG_ADDR_I[1:0] == BYTE_LANE_ZERO);
	assign soft_rst = wr_hit && (REG_ADDR_I == OFS_MODULE_RESET);
	assign wr_dev_addr = wr_hit && (REG_ADDR_I == OFS_DEVICE_ADDR);
	assign wr_otg = wr_hit && (REG_ADDR_I == OFS_OTG_CONTROL);
	assign wr_serial = wr_hit && (REG_ADDR_I == OFS_SERIAL_LINE);
	assign wr_flags = wr_hit && (REG_ADDR_I == OFS_EVENT_FLAGS);
	assign wr_sticky = wr_hit && (REG_ADDR_I == OFS_STICKINESS);
	assign wr_masks = wr_hit && (REG_ADDR_I == OFS_PORT_MASKS);
	assign wr_frame = wr_hit && (REG_ADDR_I == OFS_FRAME_COUNT);

	////////////////////////////////////////////////////////////////////////
	// device address

	logic [DEV_ADDR_W-1:0] dev_addr_ff;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			dev_addr_ff <= DEV_ADDR_RST;
		else if (soft_rst)
			dev_addr_ff <= DEV_ADDR_RST;
		else if (wr_dev_addr)
			dev_addr_ff <= REG_WDATA_I[DEV_ADDR_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// on-the-go control

	otg_ctrl_type otg_ff;
	otg_ctrl_type nxt_otg;

	always_comb
	begin
		nxt_otg.external_vbus_indicator_select = REG_WDATA_I[OTG_EXT_IND_BIT];
		nxt_otg.external_vbus_drive = REG_WDATA_I[OTG_EXT_DRV_BIT];
		nxt_otg.vbus_charge_enable = REG_WDATA_I[OTG_CHARGE_BIT];
		nxt_otg.vbus_discharge_enable = REG_WDATA_I[OTG_DISCHARGE_BIT];
		nxt_otg.dminus_pulldown_enable = REG_WDATA_I[OTG_DM_PD_BIT];
		nxt_otg.dplus_pulldown_enable = REG_WDATA_I[OTG_DP_PD_BIT];
		nxt_otg.id_pullup_enable = REG_WDATA_I[OTG_ID_PU_BIT];
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			otg_ff <= '0;
		else if (soft_rst)
			otg_ff <= '0;
		else if (wr_otg)
			otg_ff <= nxt_otg;
	end

	assign EXT_VBUS_IND_SEL_O = otg_ff.external_vbus_indicator_select;
	assign EXT_VBUS_DRIVE_O = otg_ff.external_vbus_drive;
	assign VBUS_CHARGE_O = otg_ff.vbus_charge_enable;
	assign VBUS_DISCHARGE_O = otg_ff.vbus_discharge_enable;
	assign DM_PULLDOWN_O = otg_ff.dminus_pulldown_enable;
	assign DP_PULLDOWN_O = otg_ff.dplus_pulldown_enable;
	assign ID_PULLUP_O = otg_ff.id_pullup_enable;

	////////////////////////////////////////////////////////////////////////
	// serial line control

	serial_ctrl_type serial_ff;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			serial_ff <= SERIAL_CTRL_RST;
		else if (soft_rst)
			serial_ff <= SERIAL_CTRL_RST;
		else if (wr_serial)
			serial_ff <= REG_WDATA_I[SER_CTRL_W-1:0];
	end

	assign TX_FORCE_SE0_O = serial_ff.transmit_force_se0;
	assign TX_DATA_O = serial_ff.transmit_data_bit;
	assign TX_ENABLE_N_O = serial_ff.transmit_enable_low;
	assign FS_LS_SERIAL_O = serial_ff.fs_ls_serial_select;

	////////////////////////////////////////////////////////////////////////
	// line event flags

	logic [NUM_FLAGS-1:0] sticky_ff;
	logic [NUM_FLAGS-1:0] flag_src;
	logic [NUM_FLAGS-1:0] flag_clear;
	logic [NUM_FLAGS-1:0] flags;
	logic token_match;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			sticky_ff <= '0;
		else if (soft_rst)
			sticky_ff <= '0;
		else if (wr_sticky)
			sticky_ff <= REG_WDATA_I[NUM_FLAGS-1:0];
	end

	assign token_match = TOKEN_GOOD_I && !TOKEN_IS_SOF_I &&
		(TOKEN_ADDR_I == dev_addr_ff);

	always_comb
	begin
		flag_src = '0;
		flag_src[FLAG_TOKEN_BIT] = token_match;
		flag_src[FLAG_SE0_BIT] = (line_state_sync == LS_SE0);
		flag_src[FLAG_K_BIT] = (line_state_sync == LS_K);
		flag_src[FLAG_J_BIT] = (line_state_sync == LS_J);
		flag_src[FLAG_CRC_BIT] = DATA_CRC_FAIL_I;
		flag_src[FLAG_RXACT_BIT] = phy_sync.receive_active;
		flag_src[FLAG_RXERR_BIT] = phy_sync.receive_error;
	end

	// write one to clear
	assign flag_clear = wr_flags ? REG_WDATA_I[NUM_FLAGS-1:0] : '0;

	event_flag_bank u_flags (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.soft_rst_i(soft_rst),
		.src_i(flag_src),
		.sticky_i(sticky_ff),
		.clear_i(flag_clear),
		.packet_start_i(PACKET_START_I),
		.flags_o(flags)
	);

	////////////////////////////////////////////////////////////////////////
	// port masks

	logic [NUM_PORTS*MASK_W-1:0] masks_ff;
	logic [NUM_PORTS-1:0] port_ff;
	logic [MASK_W-1:0] flags_wide;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			masks_ff <= '0;
		else if (soft_rst)
			masks_ff <= '0;
		else if (wr_masks)
			masks_ff <= REG_WDATA_I;
	end

	assign flags_wide = {1'b0, flags};

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : gen_port
			always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
					port_ff[p] <= 1'b0;
				else
					port_ff[p] <= |(flags_wide &
						masks_ff[p*MASK_W +: MASK_W]);
			end
		end
	endgenerate

	assign PORT_FLAG_O = port_ff;

	////////////////////////////////////////////////////////////////////////
	// frame counter

	logic [FRAME_W-1:0] frame_ff;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			frame_ff <= FRAME_RST;
		else if (soft_rst)
			frame_ff <= FRAME_RST;
		else if (wr_frame)
			frame_ff <= REG_WDATA_I[FRAME_W-1:0];
		else if (TOKEN_GOOD_I && TOKEN_IS_SOF_I)
			frame_ff <= TOKEN_FRAME_I;
	end

	////////////////////////////////////////////////////////////////////////
	// read data and acknowledge

	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;
	logic ack_ff;

	always_comb
	begin
		nxt_rdata = '0;
		unique case (REG_ADDR_I)
			OFS_DEVICE_ADDR:
				nxt_rdata[DEV_ADDR_W-1:0] = dev_addr_ff;
			OFS_OTG_CONTROL:
			begin
				nxt_rdata[OTG_EXT_IND_BIT] =
					otg_ff.external_vbus_indicator_select;
				nxt_rdata[OTG_EXT_DRV_BIT] = otg_ff.external_vbus_drive;
				nxt_rdata[OTG_CHARGE_BIT] = otg_ff.vbus_charge_enable;
				nxt_rdata[OTG_DISCHARGE_BIT] = otg_ff.vbus_discharge_enable;
				nxt_rdata[OTG_DM_PD_BIT] = otg_ff.dminus_pulldown_enable;
				nxt_rdata[OTG_DP_PD_BIT] = otg_ff.dplus_pulldown_enable;
				nxt_rdata[OTG_ID_PU_BIT] = otg_ff.id_pullup_enable;
			end
			OFS_OTG_STATUS:
				nxt_rdata[OTG_STATUS_W-1:0] =
					phy_sync[$bits(phy_status_type)-1 -: OTG_STATUS_W];
			OFS_SERIAL_LINE:
			begin
				nxt_rdata[SER_RX_DIFF_BIT] = phy_sync.receive_diff_line;
				nxt_rdata[SER_RX_DM_BIT] = phy_sync.receive_dminus_line;
				nxt_rdata[SER_RX_DP_BIT] = phy_sync.receive_dplus_line;
				nxt_rdata[SER_CTRL_W-1:0] = serial_ff;
			end
			OFS_EVENT_FLAGS:
				nxt_rdata[NUM_FLAGS-1:0] = flags;
			OFS_STICKINESS:
				nxt_rdata[NUM_FLAGS-1:0] = sticky_ff;
			OFS_PORT_MASKS:
				nxt_rdata = masks_ff;
			OFS_FRAME_COUNT:
				nxt_rdata[FRAME_W-1:0] = frame_ff;
			default:
				nxt_rdata = '0;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rdata_ff <= '0;
		else if (REG_RD_I)
			rdata_ff <= nxt_rdata;
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			ack_ff <= 1'b0;
		else
			ack_ff <= REG_RD_I || REG_WR_I;
	end

	assign REG_RDATA_O = rdata_ff;
	assign REG_ACK_O = ack_ff;
	assign DEVICE_ADDR_O = dev_addr_ff;

endmodule

// file: src/usb_link_pkg.sv
// constants and types of the usb link status and control block
package usb_link_pkg;

	// register offsets, byte addresses of 32-bit words
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MODULE_RESET = 8'h00;
	localparam logic [7:0] OFS_DEVICE_ADDR = 8'h08;
	localparam logic [7:0] OFS_OTG_CONTROL = 8'h10;
	localparam logic [7:0] OFS_OTG_STATUS = 8'h14;
	localparam logic [7:0] OFS_SERIAL_LINE = 8'h18;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1C;
	localparam logic [7:0] OFS_STICKINESS = 8'h20;
	localparam logic [7:0] OFS_PORT_MASKS = 8'h24;
	localparam logic [7:0] OFS_FRAME_COUNT = 8'h28;
	localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;

	// on-the-go control field positions
	localparam int OTG_EXT_IND_BIT = 7;
	localparam int OTG_EXT_DRV_BIT = 6;
	localparam int OTG_CHARGE_BIT = 4;
	localparam int OTG_DISCHARGE_BIT = 3;
	localparam int OTG_DM_PD_BIT = 2;
	localparam int OTG_DP_PD_BIT = 1;
	localparam int OTG_ID_PU_BIT = 0;

	// on-the-go status field positions
	localparam int OTG_STATUS_W = 6;

	// serial line control field positions
	localparam int SER_RX_DIFF_BIT = 6;
	localparam int SER_RX_DM_BIT = 5;
	localparam int SER_RX_DP_BIT = 4;
	localparam int SER_CTRL_W = 4;

	// event flag positions
	localparam int NUM_FLAGS = 7;
	localparam int FLAG_TOKEN_BIT = 6;
	localparam int FLAG_SE0_BIT = 5;
	localparam int FLAG_K_BIT = 4;
	localparam int FLAG_J_BIT = 3;
	localparam int FLAG_CRC_BIT = 2;
	localparam int FLAG_RXACT_BIT = 1;
	localparam int FLAG_RXERR_BIT = 0;
	// flags that copy a level instead of catching an event
	localparam logic [NUM_FLAGS-1:0] FLAG_FOLLOW_MASK = 7'h03;

	// port masks
	localparam int NUM_PORTS = 4;
	localparam int MASK_W = 8;

	// frame counter and device address
	localparam int FRAME_W = 11;
	localparam int FRAME_LOW_W = 8;
	localparam int DEV_ADDR_W = 7;

	// line state codes
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;

	// reset values
	localparam logic [SER_CTRL_W-1:0] SERIAL_CTRL_RST = 4'h2;
	localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 7'h00;
	localparam logic [FRAME_W-1:0] FRAME_RST = 11'h000;
	localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_RST = 7'h00;

	typedef struct packed {
		logic external_vbus_indicator_select;
		logic external_vbus_drive;
		logic vbus_charge_enable;
		logic vbus_discharge_enable;
		logic dminus_pulldown_enable;
		logic dplus_pulldown_enable;
		logic id_pullup_enable;
	} otg_ctrl_type;

	// field order matches register bits 3:0
	typedef struct packed {
		logic transmit_force_se0;
		logic transmit_data_bit;
		logic transmit_enable_low;
		logic fs_ls_serial_select;
	} serial_ctrl_type;

	// first six fields match status register bits 5:0
	typedef struct packed {
		logic b_session_valid_status;
		logic id_ground_status;
		logic host_disconnect_status;
		logic vbus_valid_status;
		logic session_valid_status;
		logic session_end_status;
		logic receive_diff_line;
		logic receive_dminus_line;
		logic receive_dplus_line;
		logic [1:0] line_state;
		logic receive_active;
		logic receive_error;
	} phy_status_type;

endpackage

// file: src/input_sync.sv
// two-stage synchroniser for transceiver inputs
`timescale 1ns/1ps
module input_sync
#(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule

// file: src/event_flag_bank.sv
// bank of event flags with per-flag stickiness
`timescale 1ns/1ps
module event_flag_bank
	import usb_link_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_rst_i,
	// flag sources and controls
	input wire logic [NUM_FLAGS-1:0] src_i,
	input wire logic [NUM_FLAGS-1:0] sticky_i,
	input wire logic [NUM_FLAGS-1:0] clear_i,
	input wire logic packet_start_i,
	// flag state
	output logic [NUM_FLAGS-1:0] flags_o
);

	logic [NUM_FLAGS-1:0] flag_ff;

	genvar g;
	generate
		for (g = 0; g < NUM_FLAGS; g++)
		begin : gen_flag
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					flag_ff[g] <= FLAGS_RST[g];
				else if (soft_rst_i)
					flag_ff[g] <= FLAGS_RST[g];
				// a set always beats a clear in the same cycle
				else if (src_i[g])
					flag_ff[g] <= 1'b1;
				else if (sticky_i[g])
				begin
					if (clear_i[g])
						flag_ff[g] <= 1'b0;
				end
				else if (FLAG_FOLLOW_MASK[g])
					flag_ff[g] <= 1'b0;
				else if (packet_start_i || clear_i[g])
					flag_ff[g] <= 1'b0;
			end
		end
	endgenerate

	assign flags_o = flag_ff;

endmodule

// file: tb/usb_link_status_ctrl_props.sv
// port assertions of the usb link status and control block
`timescale 1ns/1ps
module usb_link_props
	import usb_link_pkg::*;
(
	// clock, reset and register port
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic [31:0] REG_RDATA_O,
	input wire logic REG_ACK_O,
	// control outputs
	input wire logic EXT_VBUS_IND_SEL_O,
	input wire logic EXT_VBUS_DRIVE_O,
	input wire logic VBUS_CHARGE_O,
	input wire logic VBUS_DISCHARGE_O,
	input wire logic DM_PULLDOWN_O,
	input wire logic DP_PULLDOWN_O,
	input wire logic ID_PULLUP_O,
	input wire logic TX_FORCE_SE0_O,
	input wire logic TX_DATA_O,
	input wire logic TX_ENABLE_N_O,
	input wire logic FS_LS_SERIAL_O,
	input wire logic [DEV_ADDR_W-1:0] DEVICE_ADDR_O
);
	wire [1:0] otg_high = {EXT_VBUS_IND_SEL_O, EXT_VBUS_DRIVE_O};
	wire [4:0] otg_low = {VBUS_CHARGE_O, VBUS_DISCHARGE_O, DM_PULLDOWN_O,
		DP_PULLDOWN_O, ID_PULLUP_O};
	wire [3:0] ser = {TX_FORCE_SE0_O, TX_DATA_O, TX_ENABLE_N_O, FS_LS_SERIAL_O};
	wire wr_otg = REG_WR_I && REG_ADDR_I == OFS_OTG_CONTROL;
	wire wr_ser = REG_WR_I && REG_ADDR_I == OFS_SERIAL_LINE;
	wire wr_dev = REG_WR_I && REG_ADDR_I == OFS_DEVICE_ADDR;
	wire wr_rst = REG_WR_I && REG_ADDR_I == OFS_MODULE_RESET;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	property p_ack;
		REG_ACK_O == $past(REG_WR_I || REG_RD_I);
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not one cycle after strobe");
	property p_otg_high;
		wr_otg |=> otg_high == $past(REG_WDATA_I[7:6]);
	endproperty
	a_otg_high: assert property (p_otg_high)
		else $error("vbus select or drive not written");
	property p_otg_low;
		wr_otg |=> otg_low == $past(REG_WDATA_I[4:0]);
	endproperty
	a_otg_low: assert property (p_otg_low)
		else $error("otg transceiver controls not written");
	property p_serial;
		wr_ser |=> ser == $past(REG_WDATA_I[3:0]);
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial controls not written");
	property p_dev_addr;
		wr_dev |=> DEVICE_ADDR_O == $past(REG_WDATA_I[6:0]);
	endproperty
	a_dev_addr: assert property (p_dev_addr)
		else $error("device address not written");
	property p_soft_reset;
		wr_rst |=> otg_high == 2'h0 && otg_low == 5'h00
			&& ser == SERIAL_CTRL_RST && DEVICE_ADDR_O == DEV_ADDR_RST;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("reset write left state behind");
	property p_hold;
		!REG_WR_I |=> $stable({otg_high, otg_low, ser, DEVICE_ADDR_O});
	endproperty
	a_hold: assert property (p_hold)
		else $error("control output changed without a write");
	property p_unaligned;
		REG_WR_I && REG_ADDR_I[1:0] != BYTE_LANE_ZERO
			|=> $stable({otg_high, otg_low, ser, DEVICE_ADDR_O});
	endproperty
	a_unaligned: assert property (p_unaligned)
		else $error("unaligned write took effect");
	property p_reserved;
		REG_RD_I && REG_ADDR_I != OFS_PORT_MASKS
			|=> REG_RDATA_O[31:11] == 21'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved read bits not zero");
endmodule

bind usb_link_status_ctrl usb_link_props chk (
	.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O),
	.EXT_VBUS_IND_SEL_O(EXT_VBUS_IND_SEL_O),
	.EXT_VBUS_DRIVE_O(EXT_VBUS_DRIVE_O), .VBUS_CHARGE_O(VBUS_CHARGE_O),
	.VBUS_DISCHARGE_O(VBUS_DISCHARGE_O), .DM_PULLDOWN_O(DM_PULLDOWN_O),
	.DP_PULLDOWN_O(DP_PULLDOWN_O), .ID_PULLUP_O(ID_PULLUP_O),
	.TX_FORCE_SE0_O(TX_FORCE_SE0_O), .TX_DATA_O(TX_DATA_O),
	.TX_ENABLE_N_O(TX_ENABLE_N_O), .FS_LS_SERIAL_O(FS_LS_SERIAL_O),
	.DEVICE_ADDR_O(DEVICE_ADDR_O)
);

// file: tb/usb_phy_model.sv
// transceiver and packet engine model facing the block
`timescale 1ns/1ps
module usb_phy_model
	import usb_link_pkg::*;
(
	// clock
	input wire logic clk_i,
	// transceiver levels
	output logic [5:0] session_o,
	output logic [2:0] rx_lines_o,
	output logic [1:0] line_state_o,
	output logic rx_active_o,
	output logic rx_error_o,
	// packet engine events
	output logic packet_start_o,
	output logic data_crc_fail_o,
	output logic token_good_o,
	output logic token_sof_o,
	output logic [DEV_ADDR_W-1:0] token_addr_o,
	output logic [FRAME_W-1:0] token_frame_o
);
	initial
	begin
		{session_o, rx_lines_o, rx_active_o, rx_error_o} = 11'h000;
		line_state_o = 2'h3;
		{packet_start_o, data_crc_fail_o, token_good_o, token_sof_o} = 4'h0;
		token_addr_o = 7'h00;
		token_frame_o = 11'h000;
	end

	// line levels, changed off the sampling edge
	task automatic levels(input logic [5:0] s, input logic [2:0] r,
		input logic [1:0] l, input logic a, input logic e);
		@(negedge clk_i);
		session_o = s;
		rx_lines_o = r;
		line_state_o = l;
		rx_active_o = a;
		rx_error_o = e;
	endtask

	// one-cycle event; token fields invalid once it ends
	task automatic pulse(input logic [3:0] ev, input logic [6:0] a,
		input logic [10:0] f);
		@(negedge clk_i);
		{packet_start_o, data_crc_fail_o, token_good_o, token_sof_o} = ev;
		token_addr_o = a;
		token_frame_o = f;
		@(negedge clk_i);
		{packet_start_o, data_crc_fail_o, token_good_o, token_sof_o} = 4'h0;
		token_addr_o = ~a;
		token_frame_o = ~f;
	endtask
endmodule

// file: tb/usb_link_status_ctrl_test.sv
// self-checking bench of the usb link status and control block
`timescale 1ns/1ps
module usb_link_status_ctrl_test
	import usb_link_pkg::*;
();
	logic clk;
	logic rst_n;
	logic reg_wr;
	logic reg_rd;
	logic [ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic ack;
	logic [6:0] otg;
	logic [3:0] ser;
	logic [6:0] dev_addr;
	logic [3:0] port;
	logic [5:0] sess;
	logic [2:0] rxl;
	logic [1:0] ls;
	logic act, err, pkt, crc, tok, sof;
	logic [6:0] taddr;
	logic [10:0] frame;
	int fail_count = 0;
	int num_checks = 0;
	int i;
	logic [7:0] ofs [9] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
		8'h24, 8'h28, 8'h3C};
	logic [31:0] ones [9] = '{32'h7F, 32'hDF, 32'h0, 32'hF, 32'h0, 32'h7F,
		32'hFFFFFFFF, 32'h7FF, 32'h0};

	usb_link_status_ctrl dut (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
		.REG_ACK_O(ack), .B_SESSION_VALID_I(sess[5]), .ID_GROUND_I(sess[4]),
		.HOST_DISCONNECT_I(sess[3]), .VBUS_VALID_I(sess[2]),
		.SESSION_VALID_I(sess[1]), .SESSION_END_I(sess[0]),
		.RX_DIFF_I(rxl[2]), .RX_DMINUS_I(rxl[1]), .RX_DPLUS_I(rxl[0]),
		.LINE_STATE_I(ls), .RX_ACTIVE_I(act), .RX_ERROR_I(err),
		.PACKET_START_I(pkt), .TOKEN_GOOD_I(tok), .TOKEN_IS_SOF_I(sof),
		.TOKEN_ADDR_I(taddr), .TOKEN_FRAME_I(frame), .DATA_CRC_FAIL_I(crc),
		.EXT_VBUS_IND_SEL_O(otg[6]), .EXT_VBUS_DRIVE_O(otg[5]),
		.VBUS_CHARGE_O(otg[4]), .VBUS_DISCHARGE_O(otg[3]),
		.DM_PULLDOWN_O(otg[2]), .DP_PULLDOWN_O(otg[1]), .ID_PULLUP_O(otg[0]),
		.TX_FORCE_SE0_O(ser[3]), .TX_DATA_O(ser[2]), .TX_ENABLE_N_O(ser[1]),
		.FS_LS_SERIAL_O(ser[0]), .DEVICE_ADDR_O(dev_addr), .PORT_FLAG_O(port)
	);

	usb_phy_model phy (
		.clk_i(clk), .session_o(sess), .rx_lines_o(rxl), .line_state_o(ls),
		.rx_active_o(act), .rx_error_o(err), .packet_start_o(pkt),
		.data_crc_fail_o(crc), .token_good_o(tok), .token_sof_o(sof),
		.token_addr_o(taddr), .token_frame_o(frame)
	);

	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// strobe held for one edge, bus released to inverted values after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		addr = ~a;
		chk("ack", 32'h1, {31'h0, ack});
		chk($sformatf("reg %h", a), e, rdata);
	endtask

	task automatic rd_reset_all;
		for (i = 0; i < 9; i++)
			rd(ofs[i], ofs[i] == OFS_SERIAL_LINE ? {28'h0, SERIAL_CTRL_RST}
				: 32'h0);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// the tests need well under a thousand cycles
	initial
	begin
		#(4000 * 40);
		fail_count++;
		wrap_up();
	end

	initial
	begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		idle(16);
		rst_n = 1'b1;
		rd_reset_all();
		$display("test reset values done");
		for (i = 0; i < 9; i++)
			wr(ofs[i], 32'hFFFFFFFF);
		for (i = 0; i < 9; i++)
			rd(ofs[i], ones[i]);
		chk("otg pins", 32'h7F, {25'h0, otg});
		chk("serial pins", 32'hF, {28'h0, ser});
		$display("test register access done");
		wr(OFS_MODULE_RESET, 32'h0);
		wr(8'h29, 32'h7FF);
		rd_reset_all();
		chk("serial pins", {28'h0, SERIAL_CTRL_RST}, {28'h0, ser});
		$display("test soft reset done");
		phy.levels(6'h2A, 3'h5, 2'h3, 1'b0, 1'b0);
		idle(4);
		rd(OFS_OTG_STATUS, 32'h2A);
		rd(OFS_SERIAL_LINE, 32'h52);
		phy.levels(6'h15, 3'h2, 2'h3, 1'b0, 1'b0);
		idle(4);
		rd(OFS_OTG_STATUS, 32'h15);
		rd(OFS_SERIAL_LINE, 32'h22);
		$display("test status lines done");
		phy.levels(6'h0, 3'h0, LS_K, 1'b0, 1'b0);
		idle(4);
		rd(OFS_EVENT_FLAGS, 32'h10);
		phy.levels(6'h0, 3'h0, LS_J, 1'b0, 1'b0);
		idle(4);
		rd(OFS_EVENT_FLAGS, 32'h18);
		phy.pulse(4'h8, 7'h00, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h08);
		phy.levels(6'h0, 3'h0, LS_SE0, 1'b0, 1'b0);
		idle(4);
		rd(OFS_EVENT_FLAGS, 32'h28);
		phy.levels(6'h0, 3'h0, 2'h3, 1'b0, 1'b0);
		idle(3);
		phy.pulse(4'h8, 7'h00, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h0);
		$display("test line flags done");
		phy.pulse(4'h4, 7'h00, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h04);
		phy.pulse(4'h8, 7'h00, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h0);
		wr(OFS_STICKINESS, 32'h04);
		phy.pulse(4'h4, 7'h00, 11'h000);
		phy.pulse(4'h8, 7'h00, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h04);
		wr(OFS_EVENT_FLAGS, 32'h04);
		rd(OFS_EVENT_FLAGS, 32'h0);
		$display("test sticky flags done");
		wr(OFS_DEVICE_ADDR, 32'h15);
		phy.pulse(4'h2, 7'h15, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h40);
		phy.pulse(4'h8, 7'h00, 11'h000);
		phy.pulse(4'h2, 7'h16, 11'h000);
		rd(OFS_EVENT_FLAGS, 32'h0);
		phy.pulse(4'h3, 7'h15, 11'h5A3);
		rd(OFS_FRAME_COUNT, 32'h5A3);
		rd(OFS_EVENT_FLAGS, 32'h0);
		$display("test tokens done");
		wr(OFS_PORT_MASKS, 32'h10080402);
		phy.levels(6'h0, 3'h0, 2'h3, 1'b1, 1'b1);
		idle(5);
		rd(OFS_EVENT_FLAGS, 32'h03);
		chk("port outputs", 32'h1, {28'h0, port});
		phy.pulse(4'h4, 7'h00, 11'h000);
		idle(1);
		chk("port outputs", 32'h3, {28'h0, port});
		phy.levels(6'h0, 3'h0, 2'h3, 1'b0, 1'b0);
		idle(4);
		rd(OFS_EVENT_FLAGS, 32'h04);
		chk("port outputs", 32'h2, {28'h0, port});
		$display("test port masks done");
		wrap_up();
	end
endmodule
